// ---- status_pkg.sv ----
`default_nettype none
package status_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [3:0] first_status_offset  = 4'h1;
  localparam logic [3:0] second_status_offset = 4'h2;
  localparam logic [3:0] error_flags_offset   = 4'h3;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int parity_bit       = 0;
  localparam int discard_bit      = 1;
  localparam int enable_valid_bit = 2;
  localparam int fault_a_bit      = 3;
  localparam int fault_b_bit      = 4;
  localparam int mode_lsb         = 5;
  localparam int class_a_bit      = 8;
  localparam int class_b_bit      = 9;
  localparam int inhibit_bit      = 10;
  localparam int violation_bit    = 11;
  localparam int act_bit          = 7;
  localparam int sec_ready_bit    = 6;
  localparam int err_sum_bit      = 11;
  localparam int link_loss_bit    = 2;
  localparam int conv_err_bit     = 6;
  localparam int serial_err_bit   = 8;
  localparam int shoot_err_bit    = 9;
  localparam int en_err_bit       = 10;
  localparam int prim_rst_bit     = 11;
  localparam int ext_rst_bit      = 12;

  // ****************************************************
  // Reset values and constants
  // ****************************************************
  localparam logic [2:0]  mode_reset     = 3'h0;
  localparam logic [2:0]  active_mode    = 3'h4;
  localparam logic [15:0] flags_reset    = 16'h1800;
  localparam logic [15:0] unmapped_word  = 16'h0000;

  typedef enum logic [1:0] {
    clr_none   = 2'b00,
    clr_sticky = 2'b01
  } clear_kind_t;

endpackage : status_pkg
`default_nettype wire

// ---- flag_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface flag_if;
  logic [15:0] flags;
  logic [15:0] clear_mask;
  logic [4:0]  set_events;
  logic        inhibit_active;
  logic        violation_active;
  logic        sec_ready;
  modport keeper (output flags, input clear_mask, set_events, inhibit_active, violation_active, sec_ready);
  modport owner  (input flags, output clear_mask, set_events, inhibit_active, violation_active, sec_ready);
endinterface : flag_if
`default_nettype wire

// ---- error_flags.sv ----
`timescale 1ns/1ns
`default_nettype none
module error_flags (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // Flag group
  flag_if.keeper    fi
);

  typedef struct packed {
    logic [15:0] flags;
  } flags_state_t;

  flags_state_t state_r;
  flags_state_t state_nxt;

  // Event index: 0 ext reset, 1 primary reset, 2 enable, 3 serial, 4 shoot-through
  always_comb begin
    state_nxt = state_r;
    // Hold-off: a clear of bits 9, 6 and 2 is ignored while its cause is still active
    if (fi.clear_mask[status_pkg::ext_rst_bit])
      state_nxt.flags[status_pkg::ext_rst_bit] = 1'b0;
    if (fi.clear_mask[status_pkg::prim_rst_bit])
      state_nxt.flags[status_pkg::prim_rst_bit] = 1'b0;
    if (fi.clear_mask[status_pkg::en_err_bit])
      state_nxt.flags[status_pkg::en_err_bit] = 1'b0;
    if (fi.clear_mask[status_pkg::serial_err_bit])
      state_nxt.flags[status_pkg::serial_err_bit] = 1'b0;
    if (fi.clear_mask[status_pkg::shoot_err_bit] && !fi.inhibit_active)  // see R10
      state_nxt.flags[status_pkg::shoot_err_bit] = 1'b0;
    if (fi.clear_mask[status_pkg::conv_err_bit] && !fi.violation_active)  // see R12
      state_nxt.flags[status_pkg::conv_err_bit] = 1'b0;
    if (fi.clear_mask[status_pkg::link_loss_bit] && fi.sec_ready)  // see R13
      state_nxt.flags[status_pkg::link_loss_bit] = 1'b0;
    // Sets come last so an event in a clear cycle is kept
    if (fi.set_events[0])
      state_nxt.flags[status_pkg::ext_rst_bit] = 1'b1;  // see R7
    if (fi.set_events[1])
      state_nxt.flags[status_pkg::prim_rst_bit] = 1'b1;  // see R8
    if (fi.set_events[2])
      state_nxt.flags[status_pkg::en_err_bit] = 1'b1;  // see R9
    if (fi.set_events[3])
      state_nxt.flags[status_pkg::serial_err_bit] = 1'b1;  // see R11
    if (fi.set_events[4] || fi.inhibit_active)
      state_nxt.flags[status_pkg::shoot_err_bit] = 1'b1;  // see R10
    if (fi.violation_active)
      state_nxt.flags[status_pkg::conv_err_bit] = 1'b1;  // see R12
    if (!fi.sec_ready)
      state_nxt.flags[status_pkg::link_loss_bit] = 1'b1;  // see R13
    // Reserved and frame bits never stored
    state_nxt.flags[15:13] = 3'h0;
    state_nxt.flags[7]     = 1'b0;  // see R14
    state_nxt.flags[5:3]   = 3'h0;
    state_nxt.flags[1:0]   = 2'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r.flags <= status_pkg::flags_reset;  // see R8
    end else begin
      state_r <= state_nxt;
    end
  end

  assign fi.flags = state_r.flags;

endmodule : error_flags
`default_nettype wire

// ---- primary_status_error_bank.sv ----
// Contract
// R1 - Second status bits 7:5 show the active operating mode code.
// R2 - Second status bit 4 shows fault B drive request, sticky.
// R3 - Second status bit 3 shows fault A drive request, sticky.
// R4 - Second status bit 2 is 1 while enable input is judged valid.
// R5 - Bit 1 of every word shows whether last message was discarded.
// R6 - Bit 0 of every word makes the word odd parity.
// R7 - Error bit 12 sets on external hard reset from reset/ready pin.
// R8 - Error bit 11 sets on any primary reset event.
// R9 - Error bit 10 sets when enable goes valid to invalid.
// R10 - Error bit 9 sets on shoot-through error; no clear while inhibit active.
// R11 - Error bit 8 sets on any serial interface error.
// R12 - Error bit 6 sets on converter violation; no clear while violation stands.
// R13 - Error bit 2 sets on link loss; no clear while secondary not ready.
// R14 - Error bit 7 is reserved.
// R15 - First status error summary is OR of all error bits.
// R16 - Converter violation status is OR of undervoltage and overvoltage.
// R17 - Secondary ready status reads 1 when secondary is ready.
// R18 - Sticky flags hold until host clears them over the serial interface.
`timescale 1ns/1ns
`default_nettype none
module primary_status_error_bank (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Register read port from serial interface
  input  wire logic        rd_req,
  input  wire logic [3:0]  rd_addr,
  output var  logic [15:0] rd_data,
  output var  logic        rd_valid,
  // Flag clearing from serial interface
  input  wire logic        clr_req,
  input  wire logic [15:0] clr_mask,
  // Serial message outcome
  input  wire logic        msg_done,
  input  wire logic        msg_discarded,
  // Device state inputs
  input  wire logic [2:0]  active_mode_code,
  input  wire logic        fault_a_request,
  input  wire logic        fault_b_request,
  input  wire logic        class_a_present,
  input  wire logic        class_b_present,
  input  wire logic        shoot_through_inhibit_status,
  input  wire logic        converter_undervoltage,
  input  wire logic        converter_overvoltage,
  input  wire logic        secondary_ready_pin,
  input  wire logic        enable_pin_valid,
  input  wire logic        reset_ready_pin_n,
  input  wire logic        reset_event,
  input  wire logic        serial_error_event,
  input  wire logic        shoot_through_error_event,
  // Status outputs
  output var  logic        error_summary
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [1:0]  en_sync;
    logic [1:0]  rst_sync;
    logic [1:0]  sec_ready_sync;
    logic        en_prev;
    logic        rst_prev;
    logic        enable_input_valid;
    logic        last_message_invalid;
    logic        fault_a_drive_request;
    logic        fault_b_drive_request;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        error_summary;
  } bank_state_t;

  bank_state_t state_r;
  bank_state_t state_nxt;

  flag_if fi ();

  error_flags u_flags (
    .sys_clk (sys_clk),
    .srst    (srst),
    .fi      (fi.keeper)
  );

  logic        converter_limit_violation;
  logic [15:0] first_word;
  logic [15:0] second_word;
  logic [15:0] error_word;
  logic [15:0] sel_word;

  assign converter_limit_violation = converter_undervoltage | converter_overvoltage;  // see R16
  assign fi.inhibit_active   = shoot_through_inhibit_status;
  assign fi.violation_active = converter_limit_violation;
  assign fi.sec_ready        = state_r.sec_ready_sync[1];  // see R17
  assign fi.clear_mask  = clr_req ? clr_mask : 16'h0000;  // see R18
  assign fi.set_events  = {shoot_through_error_event,
                           serial_error_event,
                           state_r.en_prev & ~state_r.en_sync[1],
                           reset_event | (state_r.rst_prev & ~state_r.rst_sync[1]),
                           state_r.rst_prev & ~state_r.rst_sync[1]};

  // ****************************************************
  // Read words
  // ****************************************************
  always_comb begin
    first_word = 16'h0000;
    first_word[status_pkg::err_sum_bit] = |fi.flags;  // see R15
    first_word[status_pkg::act_bit]     = (active_mode_code == status_pkg::active_mode);
    first_word[status_pkg::sec_ready_bit] = fi.sec_ready;  // see R17
    first_word[status_pkg::discard_bit]   = state_r.last_message_invalid;

    second_word = 16'h0000;
    second_word[status_pkg::violation_bit]    = converter_limit_violation;
    second_word[status_pkg::inhibit_bit]      = shoot_through_inhibit_status;
    second_word[status_pkg::class_b_bit]      = class_b_present;
    second_word[status_pkg::class_a_bit]      = class_a_present;
    second_word[status_pkg::mode_lsb+:3]      = active_mode_code;  // see R1
    second_word[status_pkg::fault_b_bit]      = state_r.fault_b_drive_request;  // see R2
    second_word[status_pkg::fault_a_bit]      = state_r.fault_a_drive_request;  // see R3
    second_word[status_pkg::enable_valid_bit] = state_r.enable_input_valid;  // see R4
    second_word[status_pkg::discard_bit]      = state_r.last_message_invalid;

    error_word = fi.flags;
    error_word[status_pkg::discard_bit] = state_r.last_message_invalid;  // see R5

    unique case (rd_addr)
      status_pkg::first_status_offset:  sel_word = first_word;
      status_pkg::second_status_offset: sel_word = second_word;
      status_pkg::error_flags_offset:   sel_word = error_word;
      default: begin
        sel_word = status_pkg::unmapped_word;
        sel_word[status_pkg::discard_bit] = state_r.last_message_invalid;
      end
    endcase
    sel_word[status_pkg::parity_bit] = ~(^sel_word[15:1]);  // see R6
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    state_nxt = state_r;
    state_nxt.en_sync   = {state_r.en_sync[0], enable_pin_valid};
    state_nxt.rst_sync  = {state_r.rst_sync[0], reset_ready_pin_n};
    state_nxt.sec_ready_sync = {state_r.sec_ready_sync[0], secondary_ready_pin};
    state_nxt.en_prev   = state_r.en_sync[1];
    state_nxt.rst_prev  = state_r.rst_sync[1];
    state_nxt.enable_input_valid = state_r.en_sync[1];  // see R4
    if (msg_done)
      state_nxt.last_message_invalid = msg_discarded;  // see R5
    // Sticky requests: set wins over a clear in the same cycle
    if (clr_req && clr_mask[status_pkg::fault_b_bit])
      state_nxt.fault_b_drive_request = 1'b0;
    if (clr_req && clr_mask[status_pkg::fault_a_bit])
      state_nxt.fault_a_drive_request = 1'b0;
    if (fault_b_request)
      state_nxt.fault_b_drive_request = 1'b1;  // see R2
    if (fault_a_request)
      state_nxt.fault_a_drive_request = 1'b1;  // see R3
    state_nxt.rd_valid = rd_req;
    state_nxt.rd_data  = rd_req ? sel_word : state_r.rd_data;
    state_nxt.error_summary = |fi.flags;  // see R15
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= '0;
      state_r.rst_sync  <= 2'h3;
      state_r.rst_prev  <= 1'b1;
      state_r.rd_data   <= 16'h0001;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rd_data       = state_r.rd_data;
  assign rd_valid      = state_r.rd_valid;
  assign error_summary = state_r.error_summary;

endmodule : primary_status_error_bank
`default_nettype wire

// ---- status_bank_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****
// Bank checks
// ****
module status_bank_assertions (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // Host port
  input wire logic        rd_req,
  input wire logic [3:0]  rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        clr_req,
  input wire logic        msg_done,
  input wire logic        msg_discarded,
  // Device state
  input wire logic [2:0]  active_mode_code,
  input wire logic        converter_undervoltage,
  input wire logic        converter_overvoltage,
  input wire logic        secondary_ready_pin,
  input wire logic        serial_error_event,
  input wire logic        error_summary
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_flag_read; rd_req && rd_addr == 4'h3 && !clr_req; endsequence
  sequence s_msg; msg_done ##1 rd_req; endsequence
  property p_answer; rd_req |=> rd_valid; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_parity; rd_valid |-> ^rd_data; endproperty
  a_parity: assert property (p_parity) else $error("word parity even");
  property p_mode; rd_req && rd_addr == 4'h2 && $stable(active_mode_code) |=> rd_data[7:5] == $past(active_mode_code);
  endproperty
  a_mode: assert property (p_mode) else $error("mode field wrong");
  property p_discard; s_msg |=> rd_data[1] == $past(msg_discarded, 2); endproperty
  a_discard: assert property (p_discard) else $error("discard bit wrong");
  property p_serial; serial_error_event ##1 s_flag_read |=> rd_data[8]; endproperty
  a_serial: assert property (p_serial) else $error("serial flag missing");
  property p_conv; (converter_undervoltage || converter_overvoltage) [*3] ##0 s_flag_read |=> rd_data[6]; endproperty
  a_conv: assert property (p_conv) else $error("converter flag missing");
  property p_link; !secondary_ready_pin [*8] ##0 s_flag_read |=> rd_data[2]; endproperty
  a_link: assert property (p_link) else $error("link flag missing");
  property p_summary; serial_error_event |-> ##[1:3] error_summary; endproperty
  a_summary: assert property (p_summary) else $error("summary not raised");
endmodule : status_bank_assertions
bind primary_status_error_bank status_bank_assertions u_status_bank_assertions (
  .sys_clk(sys_clk), .srst(srst), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
  .clr_req(clr_req), .msg_done(msg_done), .msg_discarded(msg_discarded), .active_mode_code(active_mode_code),
  .converter_undervoltage(converter_undervoltage), .converter_overvoltage(converter_overvoltage),
  .secondary_ready_pin(secondary_ready_pin), .serial_error_event(serial_error_event), .error_summary(error_summary));
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****
// Host stand-in
// ****
module host_model (
  // Clock
  input  wire logic        sys_clk,
  // Answer
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  // Requests
  output var  logic        rd_req = 1'b0,
  output var  logic [3:0]  rd_addr = 4'h0,
  output var  logic        clr_req = 1'b0,
  output var  logic [15:0] clr_mask = 16'h0000
);
  // Idle address inverted so a stale value never looks valid
  task automatic read(input logic [3:0] a, output logic [15:0] w, output logic ok);
    @(negedge sys_clk);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge sys_clk);
    rd_req = 1'b0;
    rd_addr = ~a;
    ok = rd_valid;
    w = rd_data;
  endtask : read
  task automatic clear(input logic [15:0] m);
    @(negedge sys_clk);
    clr_req = 1'b1;
    clr_mask = m;
    @(negedge sys_clk);
    clr_req = 1'b0;
    clr_mask = ~m;
  endtask : clear
endmodule : host_model
`default_nettype wire

// ---- test_primary_status_error_bank.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****
// Bank bench
// ****
module test_primary_status_error_bank;
  logic        sys_clk, srst, rd_req, rd_valid, clr_req, md, mdis, fa, fb, ca, cb, inh, uv, ov;
  logic        sready, en, rst_pin_n, rev, sev, tev, esum, ok, disc;
  logic [2:0]  mode;
  logic [3:0]  rd_addr;
  logic [15:0] rd_data, clr_mask, word;
  int          n_errors = 0, tests_run = 0, cycles = 0;
  integer      seed;
  primary_status_error_bank u_primary_status_error_bank (
    .sys_clk(sys_clk), .srst(srst), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .clr_req(clr_req), .clr_mask(clr_mask), .msg_done(md), .msg_discarded(mdis),
    .active_mode_code(mode), .fault_a_request(fa), .fault_b_request(fb), .class_a_present(ca),
    .class_b_present(cb), .shoot_through_inhibit_status(inh), .converter_undervoltage(uv),
    .converter_overvoltage(ov), .secondary_ready_pin(sready), .enable_pin_valid(en), .reset_ready_pin_n(rst_pin_n),
    .reset_event(rev), .serial_error_event(sev), .shoot_through_error_event(tev), .error_summary(esum));
  host_model u_host_model (.sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid), .rd_req(rd_req),
    .rd_addr(rd_addr), .clr_req(clr_req), .clr_mask(clr_mask));
  function automatic logic [15:0] seal(input logic [15:0] body);
    logic [15:0] w;
    w = {body[15:2], disc, 1'b0};
    w[0] = ~^w[15:1];
    return w;
  endfunction : seal
  function automatic logic [15:0] st2(input logic b, input logic a);
    return seal({4'h0, uv | ov, inh, cb, ca, mode, b, a, en, 2'b00});
  endfunction : st2
  function automatic logic [15:0] st1(input logic err);
    return seal({4'h0, err, 3'h0, mode == status_pkg::active_mode, sready, 6'h00});
  endfunction : st1
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rd_check(input string what, input logic [3:0] a, input logic [15:0] exp);
    u_host_model.read(a, word, ok);
    check(what, exp, word);
    check("rd_valid", 16'h0001, {15'h0000, ok});
  endtask : rd_check
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Run needs about a hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    seed = 32'hDDBF3D50;
    {srst, sready, en, rst_pin_n} = 4'hF;
    {md, mdis, fa, fb, ca, cb, inh, uv, ov, rev, sev, tev, disc} = 13'h0000;
    mode = 3'h0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    // Pins pass a synchroniser, so let it settle first
    repeat (6) @(negedge sys_clk);
    check("summary_rst", 16'h0001, {15'h0000, esum});
    u_host_model.read(4'h3, word, ok);
    check("flags_rst", 16'h0018, {8'h00, word[15:8]});
    rd_check("status1_rst", 4'h1, st1(1'b1));
    u_host_model.clear(16'hFFFF);
    rd_check("flags_clr", 4'h3, seal(16'h0000));
    check("summary_clr", 16'h0000, {15'h0000, esum});
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      @(negedge sys_clk);
      {mode, ca, cb, inh, uv, ov} = 8'($random(seed));
      rd_check("status2", 4'h2, st2(1'b0, 1'b0));
    end
    {inh, uv, ov} = 3'h0;
    $display("random status test done");
    @(negedge sys_clk);
    {fa, fb} = 2'b11;
    @(negedge sys_clk);
    {fa, fb} = 2'b00;
    rd_check("fault_sticky", 4'h2, st2(1'b1, 1'b1));
    u_host_model.clear(16'h0008);
    rd_check("fault_a_clr", 4'h2, st2(1'b1, 1'b0));
    u_host_model.clear(16'hFFFF);
    $display("fault test done");
    @(negedge sys_clk);
    {sev, tev, rev, rst_pin_n, en, inh, ov, sready} = 8'hE6;
    @(negedge sys_clk);
    {sev, tev, rev, rst_pin_n} = 4'h1;
    repeat (8) @(negedge sys_clk);
    rd_check("events", 4'h3, seal(16'h1F44));
    rd_check("enable_low", 4'h2, st2(1'b0, 1'b0));
    rd_check("status1_lost", 4'h1, st1(1'b1));
    u_host_model.clear(16'hFFFF);
    rd_check("refused", 4'h3, seal(16'h0244));
    {inh, ov, sready, en} = 4'h3;
    repeat (6) @(negedge sys_clk);
    u_host_model.clear(16'hFFFF);
    rd_check("released", 4'h3, seal(16'h0000));
    mode = status_pkg::active_mode;
    rd_check("status1_act", 4'h1, st1(1'b0));
    $display("event test done");
    @(negedge sys_clk);
    {md, mdis, sev, tev, rev} = 5'h1F;
    {md, sev, tev, rev} <= #10 4'h0;
    disc = 1'b1;
    rd_check("discard_set", 4'h3, seal(16'h0B00));
    rd_check("unmapped", 4'h7, seal(16'h0000));
    check("summary_set", 16'h0001, {15'h0000, esum});
    @(negedge sys_clk);
    {md, mdis} = 2'b10;
    md <= #10 1'b0;
    disc = 1'b0;
    rd_check("discard_clr", 4'h2, st2(1'b0, 1'b0));
    $display("message test done");
    conclude();
  end
endmodule : test_primary_status_error_bank
`default_nettype wire
